// File: logic/eep_cfg.svh
// Purpose: Constants for the byte-erasable nonvolatile array controller.
// Assumes: Registers sit at printed indexes; the byte address is four times the index.
// Notes: Definitions only.
`ifndef EEP_CFG_SVH
`define EEP_CFG_SVH

// Register indexes and bus address width.
`define EEP_IDX_PROGRAM_CONTROL 9'h007
`define EEP_IDX_OPTIONS 9'h100
`define EEP_ADDR_W 11
`define EEP_IDX_W 9

// Control register field positions.
`define EEP_BIT_PUMP 0
`define EEP_BIT_LATCH 1
`define EEP_BIT_ERASE 2
`define EEP_BIT_CLKOUT 3

// Options byte field positions.
`define EEP_BIT_SECURITY 0
`define EEP_BIT_PROTECT 1

// Array geometry: the lower 32 bytes are never protected.
`define EEP_ARRAY_DEPTH 256
`define EEP_UNPROTECTED_TOP 8'h1F
`define EEP_LAST_INDEX 8'hFF

// Data values.
`define EEP_ERASED_BYTE 8'hFF
`define EEP_BLANK_READ 8'hFF
`define EEP_CTRL_RESET 8'h00

`endif

// File: logic/eep_pkg.sv
// Purpose: Types shared by the array controller and its bench.
// Assumes: Constants come from eep_cfg.svh.
// Notes: Control bits travel together as one packed struct.
package eep_pkg;

    // Control register image, most significant field first.
    typedef struct packed {
        logic bus_clock_output_enable;
        logic erase_select;
        logic latch_enable;
        logic pump_enable;
    } eep_ctrl_t;

    // Options latches caught from the options byte.
    typedef struct packed {
        logic upper_region_protect;
        logic security_lock;
    } eep_opts_t;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        EEP_ST_LOAD = 3'b001,
        EEP_ST_RUN = 3'b010,
        EEP_ST_WIPE = 3'b100
    } eep_state_t;

endpackage

// File: logic/eep_ctrl.sv
// Purpose: Control of a 256-byte byte-erasable nonvolatile array behind an Avalon-MM slave.
// Assumes: Software times erase and program waits; halt and self-check arrive as synchronous levels.
// Notes: Program and erase are committed to the array when latch-enable is cleared with the pump on.
`include "eep_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module eep_ctrl (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Avalon-MM slave, byte address.
    input wire logic [`EEP_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Chip mode inputs.
    input wire logic halt_entry,
    input wire logic self_check_entry,
    // Status outputs.
    output logic pump_active,
    output logic bus_clock_output_enable,
    output logic test_mode_allowed,
    output eep_pkg::eep_opts_t options_latched
);
    import eep_pkg::*;

    logic [7:0] mem [0:`EEP_ARRAY_DEPTH-1];

    eep_ctrl_t ctrl_r;
    eep_opts_t opts_r;
    eep_state_t state_r;
    logic [7:0] wipe_cnt_r;
    logic captured_r;
    logic [7:0] cap_addr_r;
    logic [7:0] cap_data_r;
    logic ack_r;
    logic [31:0] rdata_r;

    logic [`EEP_IDX_W-1:0] idx;
    logic hit_array;
    logic hit_ctrl;
    logic req;
    logic blocked;
    logic wr_done;
    logic wr_ctrl;
    logic commit;

    // Array window covers indexes 0x100 to 0x1FF.
    function automatic logic in_array(input logic [`EEP_IDX_W-1:0] i);
        in_array = i[8];
    endfunction

    // Upper region is locked while the protect latch is zero.
    function automatic logic locked(input logic [7:0] a, input logic prot);
        locked = !prot && (a > `EEP_UNPROTECTED_TOP);
    endfunction

    assign idx = avs_address[`EEP_ADDR_W-1:2];
    assign hit_array = in_array(idx);
    assign hit_ctrl = (idx == `EEP_IDX_PROGRAM_CONTROL);
    assign req = avs_read | avs_write;

    // Array accesses stall while the pump drives the array or the sequencer is busy.
    assign blocked = hit_array && (ctrl_r.pump_enable || state_r != EEP_ST_RUN);
    assign avs_waitrequest = req && !ack_r;
    assign wr_done = avs_write && ack_r && avs_byteenable[0];
    assign wr_ctrl = wr_done && hit_ctrl;

    // Operation ends when software drops latch-enable with the pump running.
    assign commit = wr_ctrl && !avs_writedata[`EEP_BIT_LATCH] && ctrl_r.pump_enable
        && captured_r && !halt_entry;

    // Handshake: one wait cycle, then the answer stands for one edge.
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r && !blocked;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else if (req && !ack_r && !blocked && avs_read) begin
            if (hit_ctrl) begin
                rdata_r <= {28'h000_0000, ctrl_r};
            end else if (hit_array && ctrl_r.latch_enable) begin
                rdata_r <= {24'h00_0000, `EEP_BLANK_READ};
            end else if (hit_array) begin
                rdata_r <= {24'h00_0000, mem[idx[7:0]]};
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end
    end

    assign avs_readdata = rdata_r;

    // Control register.
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r <= eep_ctrl_t'(`EEP_CTRL_RESET);
        end else if (halt_entry || state_r == EEP_ST_WIPE) begin
            ctrl_r.erase_select <= 1'b0;
            ctrl_r.latch_enable <= 1'b0;
            ctrl_r.pump_enable <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_r.bus_clock_output_enable <= avs_writedata[`EEP_BIT_CLKOUT];
            ctrl_r.latch_enable <= avs_writedata[`EEP_BIT_LATCH];
            if (!avs_writedata[`EEP_BIT_LATCH]) begin
                ctrl_r.erase_select <= 1'b0;
                ctrl_r.pump_enable <= 1'b0;
            end else begin
                if (!captured_r) begin
                    ctrl_r.erase_select <= avs_writedata[`EEP_BIT_ERASE];
                end
                if (!ctrl_r.pump_enable) begin
                    ctrl_r.pump_enable <= avs_writedata[`EEP_BIT_PUMP] && captured_r;
                end
            end
        end
    end

    // Capture of the target address and data.
    always_ff @(posedge clk) begin
        if (reset) begin
            captured_r <= 1'b0;
            cap_addr_r <= 8'h00;
            cap_data_r <= 8'h00;
        end else if (!ctrl_r.latch_enable || halt_entry) begin
            captured_r <= 1'b0;
        end else if (wr_done && hit_array && !ctrl_r.pump_enable && !captured_r) begin
            captured_r <= 1'b1;
            cap_addr_r <= idx[7:0];
            cap_data_r <= avs_writedata[7:0];
        end
    end

    // Options latches are loaded from the options byte after every reset.
    always_ff @(posedge clk) begin
        if (reset) begin
            opts_r <= eep_opts_t'(2'b00);
        end else if (state_r == EEP_ST_LOAD) begin
            opts_r.upper_region_protect <= mem[8'h00][`EEP_BIT_PROTECT];
            opts_r.security_lock <= mem[8'h00][`EEP_BIT_SECURITY];
        end
    end

    // Sequencer: load options, run, or wipe the whole array on self-check.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= EEP_ST_LOAD;
            wipe_cnt_r <= 8'h00;
        end else begin
            case (state_r)
                EEP_ST_LOAD: begin
                    state_r <= EEP_ST_RUN;
                end
                EEP_ST_RUN: begin
                    if (self_check_entry) begin
                        state_r <= EEP_ST_WIPE;
                        wipe_cnt_r <= 8'h00;
                    end
                end
                EEP_ST_WIPE: begin
                    wipe_cnt_r <= wipe_cnt_r + 8'h01;
                    if (wipe_cnt_r == `EEP_LAST_INDEX) begin
                        state_r <= EEP_ST_RUN;
                    end
                end
                default: begin
                    state_r <= EEP_ST_LOAD;
                end
            endcase
        end
    end

    // Array storage. Programming can only clear bits, so a byte must be erased first.
    always_ff @(posedge clk) begin
        if (state_r == EEP_ST_WIPE) begin
            mem[wipe_cnt_r] <= `EEP_ERASED_BYTE;
        end else if (commit && !locked(cap_addr_r, opts_r.upper_region_protect)) begin
            if (ctrl_r.erase_select) begin
                mem[cap_addr_r] <= `EEP_ERASED_BYTE;
            end else begin
                mem[cap_addr_r] <= mem[cap_addr_r] & cap_data_r;
            end
        end
    end

    assign pump_active = ctrl_r.pump_enable;
    assign bus_clock_output_enable = ctrl_r.bus_clock_output_enable;
    assign test_mode_allowed = opts_r.security_lock;
    assign options_latched = opts_r;

endmodule

`default_nettype wire

// File: tb/eep_ctrl_checker.sv
// Purpose: Port checks for the nonvolatile array controller.
// Assumes: Byte address is four times the register index.
// Notes: Bound to every instance of the controller.
`timescale 1ns/10ps
`default_nettype none
module eep_ctrl_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Bus.
    input wire logic [10:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // Mode and status.
    input wire logic halt_entry,
    input wire logic pump_active,
    input wire logic test_mode_allowed,
    input wire eep_pkg::eep_opts_t options_latched
);
    import eep_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire ctrl_wr = avs_write && !avs_waitrequest && avs_address[10:2] == 9'h007 && avs_byteenable[0];
    property p_pump_on; $rose(pump_active) |-> $past(ctrl_wr && avs_writedata[0]); endproperty
    a_pump_on: assert property (p_pump_on) else $error("pump rose without control write");
    property p_pump_off; $fell(pump_active) |-> $past(halt_entry || (ctrl_wr && !avs_writedata[1])); endproperty
    a_pump_off: assert property (p_pump_off) else $error("pump dropped without latch clear");
    property p_pump_hold; pump_active && !halt_entry && !ctrl_wr |=> pump_active; endproperty
    a_pump_hold: assert property (p_pump_hold) else $error("pump dropped on its own");
    property p_halt; halt_entry |=> !pump_active; endproperty
    a_halt: assert property (p_halt) else $error("pump on after halt");
    property p_stall; pump_active && (avs_read || avs_write) && avs_address[10] |-> avs_waitrequest; endproperty
    a_stall: assert property (p_stall) else $error("array access done while pump on");
    property p_ctrl_ans; (avs_read || avs_write) && avs_waitrequest && avs_address[10:2] == 9'h007 |=> !avs_waitrequest; endproperty
    a_ctrl_ans: assert property (p_ctrl_ans) else $error("control access not answered");
    property p_opts_hold; !$stable(options_latched) |-> $past(reset) || $past(reset, 2) || $past(reset, 3); endproperty
    a_opts_hold: assert property (p_opts_hold) else $error("options changed outside reset");
    property p_test_mode; test_mode_allowed == options_latched.security_lock; endproperty
    a_test_mode: assert property (p_test_mode) else $error("test mode not from security latch");
    c_pump: cover property ($rose(pump_active));
    c_stall: cover property (pump_active && avs_read && avs_waitrequest);
    c_halt: cover property (halt_entry && pump_active);
endmodule
bind eep_ctrl eep_ctrl_checker u_chk (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .halt_entry(halt_entry),
    .pump_active(pump_active), .test_mode_allowed(test_mode_allowed), .options_latched(options_latched));
`default_nettype wire

// File: tb/eep_ctrl_test.sv
// Purpose: Register-level test of the nonvolatile array controller.
// Assumes: Array is wiped by self-check before options are trusted.
// Notes: Byte enables stay all ones.
`timescale 1ns/10ps
`default_nettype none
module eep_ctrl_test;
    import eep_pkg::*;
    logic clk, reset, rd_q, wr_q, halt, wipe, wreq, pump, ckout, tmode;
    logic [10:0] addr;
    logic [31:0] wdata, rdata;
    logic [7:0] last;
    eep_opts_t opts;
    int error_cnt = 0, comparisons = 0, cycles = 0;
    eep_ctrl dut (.clk(clk), .reset(reset), .avs_address(addr), .avs_read(rd_q), .avs_write(wr_q),
        .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .halt_entry(halt), .self_check_entry(wipe), .pump_active(pump), .bus_clock_output_enable(ckout),
        .test_mode_allowed(tmode), .options_latched(opts));
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waitrequest is looked at on the falling edge, so the request stands through the completing rising edge.
    task automatic acc(input logic w, input logic [8:0] idx, input logic [7:0] d);
        wr_q <= w;
        rd_q <= !w;
        addr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        do @(negedge clk); while (wreq !== 1'b0);
        @(posedge clk);
        last = rdata[7:0];
        wr_q <= 1'b0;
        rd_q <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [8:0] idx, input logic [7:0] d);
        acc(1'b1, idx, d);
    endtask
    task automatic rd(input logic [8:0] idx, input logic [7:0] exp);
        acc(1'b0, idx, 8'h00);
        chk(last, exp);
    endtask
    task automatic prog(input logic [8:0] idx, input logic [7:0] d);
        wr(9'h007, 8'h02);
        wr(idx, d);
        wr(9'h007, 8'h03);
        wr(9'h007, 8'h00);
    endtask
    task automatic rst;
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 20000) begin
                error_cnt++;
                results();
            end
        end
    end
    initial begin
        {reset, rd_q, wr_q, halt, wipe, addr, wdata} = '0;
        rst();
        wipe <= 1'b1;
        @(posedge clk);
        wipe <= 1'b0;
        rd(9'h100, 8'hFF);
        rst();
        chk({6'h0, opts}, 8'h03);
        chk({7'h0, tmode}, 8'h01);
        rd(9'h007, 8'h00);
        $display("reset and wipe done");
        wr(9'h007, 8'h02);
        rd(9'h007, 8'h02);
        rd(9'h120, 8'hFF);
        wr(9'h120, 8'hA5);
        wr(9'h130, 8'h00);
        wr(9'h007, 8'h06);
        rd(9'h007, 8'h02);
        wr(9'h007, 8'h03);
        chk({7'h0, pump}, 8'h01);
        wr(9'h007, 8'h02);
        rd(9'h007, 8'h03);
        wr(9'h007, 8'h00);
        rd(9'h120, 8'hA5);
        rd(9'h130, 8'hFF);
        wr(9'h007, 8'h02);
        wr(9'h007, 8'h03);
        rd(9'h007, 8'h02);
        $display("program done");
        wr(9'h007, 8'h06);
        rd(9'h007, 8'h06);
        wr(9'h120, 8'h00);
        wr(9'h007, 8'h07);
        rd(9'h007, 8'h07);
        wr(9'h007, 8'h00);
        rd(9'h120, 8'hFF);
        $display("erase done");
        wr(9'h007, 8'h02);
        wr(9'h140, 8'h3C);
        wr(9'h007, 8'h03);
        fork
            rd(9'h140, 8'hFF);
            begin
                repeat (4) @(posedge clk);
                chk({7'h0, wreq}, 8'h01);
                halt <= 1'b1;
                repeat (2) @(posedge clk);
                halt <= 1'b0;
            end
        join
        chk({7'h0, pump}, 8'h00);
        rd(9'h007, 8'h00);
        $display("halt done");
        wr(9'h100, 8'h00);
        rd(9'h100, 8'hFF);
        prog(9'h100, 8'hFD);
        chk({6'h0, opts}, 8'h03);
        rst();
        chk({6'h0, opts}, 8'h01);
        prog(9'h150, 8'h00);
        rd(9'h150, 8'hFF);
        prog(9'h11F, 8'h00);
        rd(9'h11F, 8'h00);
        wr(9'h010, 8'h55);
        rd(9'h010, 8'h00);
        $display("protect done");
        results();
    end
endmodule
`default_nettype wire
